// file: design/dpm_pkg.sv
/*
 * Package for the drive power-mode controller: command opcodes, mode and
 * idle sub-mode encodings, the packed carriers between host command port,
 * status and spindle, and the inactivity timer timing constants.
 * Assumes a single 25 MHz device clock.
 */
package dpm_pkg;

  // Device clock and the inactivity timer unit
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TIMER_UNIT_MS = 5000;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1000) * TIMER_UNIT_MS;
  localparam int unsigned TICK_W        = 27;

  // Power-management opcodes
  localparam logic [7:0] OP_STANDBY_IMM = 8'he0;
  localparam logic [7:0] OP_IDLE_IMM    = 8'he1;
  localparam logic [7:0] OP_STANDBY     = 8'he2;
  localparam logic [7:0] OP_IDLE        = 8'he3;
  localparam logic [7:0] OP_CHECK_POWER = 8'he5;
  localparam logic [7:0] OP_SLEEP       = 8'he6;

  // Count value that turns the inactivity timer off
  localparam logic [7:0] TIMER_OFF      = 8'h00;

  // Check-power-mode answer codes
  localparam logic [7:0] PWR_STANDBY    = 8'h00;
  localparam logic [7:0] PWR_IDLE       = 8'h80;
  localparam logic [7:0] PWR_ACTIVE     = 8'hff;

  // Spindle targets in percent of full speed
  localparam logic [6:0] SPEED_FULL     = 7'h64;
  localparam logic [6:0] SPEED_LOW_MIN  = 7'h55;
  localparam logic [6:0] SPEED_LOW_MAX  = 7'h5a;
  localparam logic [6:0] SPEED_LOW      = 7'h58;

  typedef enum logic [3:0] {
    DPM_ACTIVE  = 4'h1,
    DPM_IDLE    = 4'h2,
    DPM_STANDBY = 4'h4,
    DPM_SLEEP   = 4'h8
  } dpm_mode_t;

  typedef enum logic [2:0] {
    DPM_SUB_ACTIVE_IDLE = 3'h1,
    DPM_SUB_LOW_POWER   = 3'h2,
    DPM_SUB_LOW_RPM     = 3'h4
  } dpm_idle_sub_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] count;
  } dpm_cmd_t;

  typedef struct packed {
    logic       done;
    logic [7:0] power_code;
  } dpm_resp_t;

  typedef struct packed {
    logic bsy;
    logic rdy;
    logic if_active;
  } dpm_status_t;

  typedef struct packed {
    logic       spin_on;
    logic       heads_park;
    logic [6:0] speed_pct;
  } dpm_spindle_t;

endpackage : dpm_pkg

// file: design/dpm_power_ctrl.sv
/*
 * Drive power-mode controller: active, idle, standby and sleep modes
 * driven by host power commands, an inactivity timer and resets; status
 * flags, check-power answer, media grant and spindle/head targets.
 * Assumes commands arrive as one-cycle valid pulses synchronous to the
 * clock and that the spindle controller reports when it is at speed.
 */
`timescale 1ns/1ns
`default_nettype none

module dpm_power_ctrl
  import dpm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = dpm_pkg::TICK_CYCLES
) (
  // Clock and power-on reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  // Interface resets and power-up strap
  input  wire logic           link_reset_i,
  input  wire logic           soft_reset_i,
  input  wire logic           pwr_up_standby_i,
  // Host command port
  input  wire logic           cmd_valid_i,
  input  wire dpm_pkg::dpm_cmd_t cmd_i,
  output dpm_pkg::dpm_resp_t  resp_o,
  // Device activity and media
  input  wire logic           exec_busy_i,
  input  wire logic           media_req_i,
  output logic                media_grant_o,
  // Spindle
  input  wire logic           spindle_at_speed_i,
  input  wire dpm_pkg::dpm_idle_sub_t idle_sub_i,
  output dpm_pkg::dpm_spindle_t spindle_o,
  // Status
  output dpm_pkg::dpm_status_t status_o,
  output dpm_pkg::dpm_mode_t  mode_o
);

  import dpm_pkg::*;

  dpm_mode_t mode;
  dpm_mode_t next_mode;
  logic      tick;
  logic      timer_en;
  logic [7:0] timer_load;
  logic [7:0] timer_cnt;
  logic      cmd_take;
  logic      is_idle_cmd;
  logic      is_sb_cmd;
  logic      is_load_cmd;
  logic      expire;
  logic      awake_work;

  dpm_tick_div #(
    .DIV_CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  );

  // Traffic while asleep is dropped outright
  assign cmd_take    = cmd_valid_i && (mode != DPM_SLEEP);
  assign is_idle_cmd = (cmd_i.opcode == OP_IDLE) ||
                       (cmd_i.opcode == OP_IDLE_IMM);
  assign is_sb_cmd   = (cmd_i.opcode == OP_STANDBY) ||
                       (cmd_i.opcode == OP_STANDBY_IMM);
  assign is_load_cmd = (cmd_i.opcode == OP_IDLE) ||
                       (cmd_i.opcode == OP_STANDBY);
  assign awake_work  = exec_busy_i || media_req_i;

  // Held off while work is pending, so a busy drive never spins down
  assign expire = tick && timer_en && (timer_cnt == 8'h01) &&
                  ((mode == DPM_ACTIVE) || (mode == DPM_IDLE)) &&
                  !cmd_take && !awake_work;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      DPM_SLEEP: begin
        if (link_reset_i || soft_reset_i) begin
          next_mode = DPM_STANDBY;
        end
      end
      DPM_ACTIVE, DPM_IDLE, DPM_STANDBY: begin
        if (cmd_take && (cmd_i.opcode == OP_SLEEP)) begin
          next_mode = DPM_SLEEP;
        end else if (cmd_take && is_idle_cmd) begin
          next_mode = DPM_IDLE;
        end else if (cmd_take && is_sb_cmd) begin
          next_mode = DPM_STANDBY;
        end else if (expire) begin
          next_mode = DPM_STANDBY;
        end else if (mode == DPM_ACTIVE && !awake_work) begin
          next_mode = DPM_IDLE;
        end else if (mode == DPM_IDLE && awake_work) begin
          next_mode = DPM_ACTIVE;
        end else if (mode == DPM_STANDBY &&
                     (exec_busy_i ||
                      (media_req_i && spindle_at_speed_i))) begin
          next_mode = DPM_ACTIVE;
        end
      end
    endcase
  end

  // Strap read in the synchronous reset branch, never asynchronously
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode <= pwr_up_standby_i ? DPM_STANDBY : DPM_IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  // Inactivity timer; link and soft reset leave it untouched
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timer_en   <= 1'b0;
      timer_load <= 8'h00;
      timer_cnt  <= 8'h00;
    end else if (cmd_take && is_load_cmd) begin
      timer_en   <= (cmd_i.count != TIMER_OFF);
      timer_load <= cmd_i.count;
      timer_cnt  <= cmd_i.count;
    end else if (cmd_take || expire) begin
      timer_cnt  <= timer_load;
    end else if (tick && timer_en && timer_cnt > 8'h01 &&
                 (mode == DPM_ACTIVE || mode == DPM_IDLE)) begin
      timer_cnt  <= timer_cnt - 8'h01;
    end
  end

  // Completion pulse; power code only meaningful for check-power
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      resp_o <= '0;
    end else begin
      resp_o.done       <= cmd_take;
      resp_o.power_code <= PWR_STANDBY;
      if (cmd_take && cmd_i.opcode == OP_CHECK_POWER) begin
        unique case (mode)
          DPM_STANDBY: resp_o.power_code <= PWR_STANDBY;
          DPM_IDLE:    resp_o.power_code <= PWR_IDLE;
          DPM_ACTIVE:  resp_o.power_code <= PWR_ACTIVE;
          DPM_SLEEP:   resp_o.power_code <= PWR_STANDBY;
        endcase
      end
    end
  end

  // Flags follow the mode one cycle late, so completion leads sleep
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      mode_o   <= DPM_IDLE;
    end else begin
      mode_o             <= mode;
      status_o.if_active <= (mode != DPM_SLEEP);
      // Ready is posted even before the media can be reached
      status_o.rdy       <= (mode != DPM_SLEEP);
      status_o.bsy       <= (mode == DPM_ACTIVE) && exec_busy_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      media_grant_o <= 1'b0;
    end else begin
      media_grant_o <= media_req_i &&
        ((mode == DPM_ACTIVE) || (mode == DPM_IDLE) ||
         (mode == DPM_STANDBY && spindle_at_speed_i));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      spindle_o <= '0;
    end else begin
      spindle_o.speed_pct <= SPEED_FULL;
      unique case (mode)
        DPM_ACTIVE: begin
          spindle_o.spin_on    <= 1'b1;
          spindle_o.heads_park <= 1'b0;
        end
        DPM_IDLE: begin
          spindle_o.spin_on <= 1'b1;
          case (idle_sub_i)
            DPM_SUB_LOW_POWER: spindle_o.heads_park <= 1'b1;
            DPM_SUB_LOW_RPM: begin
              spindle_o.heads_park <= 1'b1;
              spindle_o.speed_pct  <= SPEED_LOW;
            end
            default: spindle_o.heads_park <= 1'b0;
          endcase
        end
        DPM_STANDBY: begin
          // Spin up only on demand from a media request or command execution
          spindle_o.spin_on    <= media_req_i || exec_busy_i;
          spindle_o.heads_park <= 1'b1;
        end
        DPM_SLEEP: begin
          spindle_o.spin_on    <= 1'b0;
          spindle_o.heads_park <= 1'b1;
        end
      endcase
    end
  end

  default clocking dpm_cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sleep_cmd;
    cmd_take && cmd_i.opcode == OP_SLEEP;
  endsequence

  sequence s_sleep_exit;
    resp_o.done && mode == DPM_SLEEP && status_o.if_active
    ##1 !status_o.if_active;
  endsequence

  a_idle_entry: assert property (
    (cmd_take && is_idle_cmd && mode != DPM_IDLE) |=> mode == DPM_IDLE)
    else $error("idle command did not reach idle");

  a_idle_timer_load: assert property (
    (cmd_take && cmd_i.opcode == OP_IDLE && cmd_i.count != TIMER_OFF)
    |=> timer_en && timer_cnt == $past(cmd_i.count))
    else $error("idle command did not load the timer");

  a_standby_entry: assert property (
    (cmd_take && is_sb_cmd) |=> mode == DPM_STANDBY)
    else $error("standby command did not reach standby");

  a_standby_timer_load: assert property (
    (cmd_take && cmd_i.opcode == OP_STANDBY && cmd_i.count != TIMER_OFF)
    |=> timer_en && timer_load == $past(cmd_i.count))
    else $error("standby command did not load the timer");

  a_sleep_order: assert property (
    s_sleep_cmd |=> s_sleep_exit)
    else $error("sleep completion and interface drop out of order");

  a_sleep_hold: assert property (
    (mode == DPM_SLEEP && !link_reset_i && !soft_reset_i)
    |=> mode == DPM_SLEEP && !resp_o.done)
    else $error("left sleep without reset");

  a_timer_expiry: assert property (
    (tick && timer_en && timer_cnt == 8'h01 && mode == DPM_IDLE &&
     !cmd_valid_i && !exec_busy_i && !media_req_i)
    |=> mode == DPM_STANDBY)
    else $error("inactivity timer expiry did not force standby");

  a_zero_disable: assert property (
    (cmd_take && is_load_cmd && cmd_i.count == TIMER_OFF) |=> !timer_en)
    else $error("zero count left the timer enabled");

  a_quiet_flags: assert property (
    (mode == DPM_IDLE || mode == DPM_STANDBY)
    |=> !status_o.bsy && status_o.rdy && status_o.if_active)
    else $error("idle or standby flags wrong");

  a_check_answer: assert property (
    (cmd_take && cmd_i.opcode == OP_CHECK_POWER && mode == DPM_IDLE)
    |=> resp_o.done && resp_o.power_code == PWR_IDLE)
    else $error("check-power answer wrong in idle");

  a_spinup_wait: assert property (
    (mode == DPM_STANDBY && !spindle_at_speed_i) |=> !media_grant_o)
    else $error("media granted before spin-up");

  a_idle_grant: assert property (
    (mode == DPM_IDLE && media_req_i) |=> media_grant_o)
    else $error("idle media request not granted at once");

  a_low_rpm: assert property (
    (mode == DPM_IDLE && idle_sub_i == DPM_SUB_LOW_RPM)
    |=> spindle_o.heads_park && spindle_o.speed_pct >= SPEED_LOW_MIN &&
        spindle_o.speed_pct <= SPEED_LOW_MAX)
    else $error("low rpm idle targets wrong");

  a_reset_wake: assert property (
    (mode == DPM_SLEEP && (link_reset_i || soft_reset_i))
    |=> mode == DPM_STANDBY)
    else $error("reset in sleep did not reach standby");

endmodule : dpm_power_ctrl

`default_nettype wire

// file: design/dpm_tick_div.sv
/*
 * Divider that turns the device clock into a one-cycle enable pulse every
 * DIV_CYCLES clocks, the time base of the inactivity timer.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none

module dpm_tick_div
  import dpm_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = dpm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Time base
  output logic      tick_o
);

  import dpm_pkg::*;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(DIV_CYCLES - 1);

  logic [TICK_W-1:0] cnt;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (cnt == LAST) begin
      cnt    <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + TICK_W'(1);
      tick_o <= 1'b0;
    end
  end

  a_tick_period: assert property (
    @(posedge ref_clk_i) disable iff (rst_i) tick_o |=> !tick_o)
    else $error("tick lasted more than one cycle");

endmodule : dpm_tick_div

`default_nettype wire

// file: tb/dpm_host_model.sv
/*
 * Host controller model: issues power commands one at a time and the
 * link or soft reset that wakes the device.
 * Assumes it shares the device clock and sees the device's answer port.
 */
`timescale 1ns/1ns
`default_nettype none

module dpm_host_model
  import dpm_pkg::*;
(
  // Clock
  input  wire logic               ref_clk_i,
  // Command and answer
  output logic                    cmd_valid_o,
  output dpm_pkg::dpm_cmd_t       cmd_o,
  input  wire dpm_pkg::dpm_resp_t resp_i,
  // Interface resets
  output logic                    link_reset_o,
  output logic                    soft_reset_o
);
  import dpm_pkg::*;

  dpm_resp_t last_resp;

  initial begin
    cmd_valid_o  = 1'b0;
    cmd_o        = '0;
    link_reset_o = 1'b0;
    soft_reset_o = 1'b0;
    last_resp    = '0;
  end

  // Payload scrambled once released, so a stale value never looks valid
  task automatic issue(input logic [7:0] op, input logic [7:0] cnt);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o       <= {op, cnt};
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o       <= ~cmd_o;
    #1 last_resp = resp_i;
  endtask : issue

  // Host must reset before commanding a sleeping device
  task automatic wake(input logic link);
    @(posedge ref_clk_i);
    link_reset_o <= link;
    soft_reset_o <= !link;
    @(posedge ref_clk_i);
    link_reset_o <= 1'b0;
    soft_reset_o <= 1'b0;
  endtask : wake
endmodule : dpm_host_model
`default_nettype wire

// file: tb/dpm_power_ctrl_test.sv
/*
 * Self-checking bench for the power-mode controller with a host model.
 * Assumes a shortened tick of TK clocks and a host model in its own file.
 */
`timescale 1ns/1ns
`default_nettype none

module dpm_power_ctrl_test;
  import dpm_pkg::*;
  localparam int unsigned TK     = 8;
  localparam logic [7:0]  OP_NOP = 8'h00;

  logic          ref_clk, rst, strap, media_req, at_speed, exec_busy;
  logic          cmd_valid, link_rst, soft_rst, grant;
  dpm_idle_sub_t idle_sub;
  dpm_cmd_t      cmd;
  dpm_resp_t     resp;
  dpm_spindle_t  spin;
  dpm_status_t   stat;
  dpm_mode_t     mode;
  int            err_total = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  dpm_power_ctrl #(.TICK_CYCLES(TK)) i_dpm_power_ctrl (
    .ref_clk_i(ref_clk), .rst_i(rst), .link_reset_i(link_rst),
    .soft_reset_i(soft_rst), .pwr_up_standby_i(strap),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .resp_o(resp),
    .exec_busy_i(exec_busy), .media_req_i(media_req),
    .media_grant_o(grant), .spindle_at_speed_i(at_speed),
    .idle_sub_i(idle_sub), .spindle_o(spin), .status_o(stat),
    .mode_o(mode));

  dpm_host_model i_dpm_host_model (
    .ref_clk_i(ref_clk), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .resp_i(resp), .link_reset_o(link_rst), .soft_reset_o(soft_rst));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Run is under two hundred cycles; ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_val(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst   <= 1'b1;
    strap <= s;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    settle(3);
  endtask : do_reset

  // Cycles until standby shows, capped
  task automatic wait_standby(output int n);
    n = 0;
    while (mode !== DPM_STANDBY && n < 40) begin
      settle(1);
      n++;
    end
  endtask : wait_standby

  task automatic t_power_up;
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    cmp_bit("rdy", 1'b1, stat.rdy);
    cmp_bit("bsy", 1'b0, stat.bsy);
    cmp_bit("if_active", 1'b1, stat.if_active);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_check_modes;
    i_dpm_host_model.issue(OP_CHECK_POWER, 8'h00);
    cmp_bit("done", 1'b1, i_dpm_host_model.last_resp.done);
    cmp_val("code", PWR_IDLE, i_dpm_host_model.last_resp.power_code);
    i_dpm_host_model.issue(OP_STANDBY_IMM, 8'h00);
    settle(1);
    cmp_val("mode", 8'(DPM_STANDBY), 8'(mode));
    cmp_bit("rdy", 1'b1, stat.rdy);
    cmp_bit("bsy", 1'b0, stat.bsy);
    i_dpm_host_model.issue(OP_CHECK_POWER, 8'h00);
    cmp_val("code", PWR_STANDBY, i_dpm_host_model.last_resp.power_code);
    i_dpm_host_model.issue(OP_IDLE_IMM, 8'h00);
    settle(1);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    $display("test check_modes done");
  endtask : t_check_modes

  task automatic t_timer;
    int n;
    i_dpm_host_model.issue(OP_IDLE, 8'h02);
    repeat (4) begin
      settle(4);
      i_dpm_host_model.issue(OP_NOP, 8'h00);
    end
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    wait_standby(n);
    cmp_bit("expiry", 1'b1, n >= TK && n <= 2 * TK + 3);
    i_dpm_host_model.issue(OP_IDLE, TIMER_OFF);
    settle(1);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    settle(4 * TK);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    i_dpm_host_model.issue(OP_STANDBY, 8'h01);
    settle(1);
    cmp_val("mode", 8'(DPM_STANDBY), 8'(mode));
    i_dpm_host_model.issue(OP_IDLE_IMM, 8'h00);
    // Old standby still shows on the take edge, so look one later
    settle(1);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    wait_standby(n);
    cmp_bit("expiry", 1'b1, n >= 1 && n <= TK + 3);
    $display("test timer done");
  endtask : t_timer

  task automatic t_media;
    // Timer off, so an expiry cannot race the media requests
    i_dpm_host_model.issue(OP_IDLE, TIMER_OFF);
    @(posedge ref_clk);
    media_req <= 1'b1;
    settle(1);
    cmp_bit("grant", 1'b1, grant);
    settle(1);
    cmp_val("mode", 8'(DPM_ACTIVE), 8'(mode));
    @(posedge ref_clk);
    media_req <= 1'b0;
    settle(3);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    i_dpm_host_model.issue(OP_STANDBY_IMM, 8'h00);
    @(posedge ref_clk);
    media_req <= 1'b1;
    settle(3);
    cmp_bit("spin_on", 1'b1, spin.spin_on);
    cmp_bit("grant", 1'b0, grant);
    @(posedge ref_clk);
    at_speed <= 1'b1;
    settle(2);
    cmp_bit("grant", 1'b1, grant);
    @(posedge ref_clk);
    media_req <= 1'b0;
    at_speed  <= 1'b0;
    i_dpm_host_model.issue(OP_IDLE_IMM, 8'h00);
    settle(1);
    @(posedge ref_clk);
    exec_busy <= 1'b1;
    settle(2);
    cmp_val("mode", 8'(DPM_ACTIVE), 8'(mode));
    cmp_bit("bsy", 1'b1, stat.bsy);
    i_dpm_host_model.issue(OP_CHECK_POWER, 8'h00);
    cmp_val("code", PWR_ACTIVE, i_dpm_host_model.last_resp.power_code);
    @(posedge ref_clk);
    exec_busy <= 1'b0;
    settle(2);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    cmp_bit("bsy", 1'b0, stat.bsy);
    $display("test media done");
  endtask : t_media

  task automatic t_low_rpm;
    @(posedge ref_clk);
    idle_sub <= DPM_SUB_LOW_RPM;
    settle(2);
    cmp_bit("heads_park", 1'b1, spin.heads_park);
    cmp_bit("speed", 1'b1, spin.speed_pct >= SPEED_LOW_MIN
                           && spin.speed_pct <= SPEED_LOW_MAX);
    @(posedge ref_clk);
    idle_sub <= DPM_SUB_ACTIVE_IDLE;
    $display("test low_rpm done");
  endtask : t_low_rpm

  task automatic t_sleep;
    i_dpm_host_model.issue(OP_SLEEP, 8'h00);
    cmp_bit("done", 1'b1, i_dpm_host_model.last_resp.done);
    cmp_bit("if_active", 1'b1, stat.if_active);
    settle(1);
    cmp_bit("if_active", 1'b0, stat.if_active);
    cmp_val("mode", 8'(DPM_SLEEP), 8'(mode));
    i_dpm_host_model.issue(OP_IDLE_IMM, 8'h00);
    cmp_bit("done", 1'b0, i_dpm_host_model.last_resp.done);
    settle(2);
    cmp_val("mode", 8'(DPM_SLEEP), 8'(mode));
    i_dpm_host_model.wake(1'b0);
    settle(2);
    cmp_val("mode", 8'(DPM_STANDBY), 8'(mode));
    cmp_bit("if_active", 1'b1, stat.if_active);
    i_dpm_host_model.issue(OP_SLEEP, 8'h00);
    i_dpm_host_model.wake(1'b1);
    settle(2);
    cmp_val("mode", 8'(DPM_STANDBY), 8'(mode));
    i_dpm_host_model.issue(OP_IDLE_IMM, 8'h00);
    i_dpm_host_model.wake(1'b1);
    settle(2);
    cmp_val("mode", 8'(DPM_IDLE), 8'(mode));
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_strap;
    do_reset(1'b1);
    cmp_val("mode", 8'(DPM_STANDBY), 8'(mode));
    cmp_bit("rdy", 1'b1, stat.rdy);
    $display("test strap done");
  endtask : t_strap

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    rst       = 1'b1;
    strap     = 1'b0;
    media_req = 1'b0;
    at_speed  = 1'b0;
    exec_busy = 1'b0;
    idle_sub  = DPM_SUB_ACTIVE_IDLE;
    do_reset(1'b0);
    t_power_up();
    t_check_modes();
    t_timer();
    t_media();
    t_low_rpm();
    t_sleep();
    t_strap();
    conclude();
  end
endmodule : dpm_power_ctrl_test
`default_nettype wire
